// [src/cgo_bank.sv]
// Purpose: Gain/offset register bank and correction for channels 14, 15
// Assumes: Single clock, synchronous reset, one-cycle read data
// Notes: Primary offset drives the datapath; mirror is stored and compared
`timescale 1ns/1ps
module cgo_bank (
  input wire logic clk,
  input wire logic sys_rst,
  input wire cgo_pkg::cgo_bus_req_t bus_req,
  output logic [15:0] rdata,
  input wire cgo_pkg::cgo_sample_t samp_in_14,
  input wire cgo_pkg::cgo_sample_t samp_in_15,
  output cgo_pkg::cgo_sample_t samp_out_14,
  output cgo_pkg::cgo_sample_t samp_out_15,
  output logic [1:0] offset_mismatch
);

  logic [15:0] gain_offset_chan_14_reg;
  logic [15:0] offset_mirror_chan_14_reg;
  logic [15:0] gain_offset_chan_15_reg;
  logic [15:0] offset_mirror_chan_15_reg;
  logic [1:0] ctrl_reg;
  logic rsvd_write_reg;
  logic [15:0] rd_mux;
  logic wr_prim14;
  logic wr_mir14;
  logic wr_prim15;
  logic wr_mir15;
  logic wr_ctrl;
  logic wr_stat;
  logic rsvd_hit;
  logic rsvd_clr;
  logic global_gain_enable;
  logic global_offset_enable;
  logic [4:0] gain_code_chan_14;
  logic [4:0] gain_code_chan_15;
  logic [9:0] offset_value_chan_14;
  logic [9:0] offset_value_chan_15;
  logic [9:0] mirror_value_chan_14;
  logic [9:0] mirror_value_chan_15;
  logic [13:0] off14_ext;

  // Write decode, one strobe per register
  assign wr_prim14 = bus_req.wr && (bus_req.addr == cgo_pkg::CGO_ADDR_PRIM14);
  assign wr_mir14 = bus_req.wr && (bus_req.addr == cgo_pkg::CGO_ADDR_MIR14);
  assign wr_prim15 = bus_req.wr && (bus_req.addr == cgo_pkg::CGO_ADDR_PRIM15);
  assign wr_mir15 = bus_req.wr && (bus_req.addr == cgo_pkg::CGO_ADDR_MIR15);
  assign wr_ctrl = bus_req.wr && (bus_req.addr == cgo_pkg::CGO_ADDR_CTRL);
  assign wr_stat = bus_req.wr && (bus_req.addr == cgo_pkg::CGO_ADDR_STAT);

  // Field views under their functional names
  assign global_gain_enable = ctrl_reg[cgo_pkg::CGO_CTRL_GAIN_BIT];
  assign global_offset_enable = ctrl_reg[cgo_pkg::CGO_CTRL_OFF_BIT];
  assign gain_code_chan_14 =
    gain_offset_chan_14_reg[cgo_pkg::CGO_GAIN_MSB:cgo_pkg::CGO_GAIN_LSB];
  assign gain_code_chan_15 =
    gain_offset_chan_15_reg[cgo_pkg::CGO_GAIN_MSB:cgo_pkg::CGO_GAIN_LSB];
  assign offset_value_chan_14 =
    gain_offset_chan_14_reg[cgo_pkg::CGO_OFF_MSB:cgo_pkg::CGO_OFF_LSB];
  assign offset_value_chan_15 =
    gain_offset_chan_15_reg[cgo_pkg::CGO_OFF_MSB:cgo_pkg::CGO_OFF_LSB];
  assign mirror_value_chan_14 =
    offset_mirror_chan_14_reg[cgo_pkg::CGO_OFF_MSB:cgo_pkg::CGO_OFF_LSB];
  assign mirror_value_chan_15 =
    offset_mirror_chan_15_reg[cgo_pkg::CGO_OFF_MSB:cgo_pkg::CGO_OFF_LSB];

  // Channel 14 primary; reserved bit is kept as written, not masked
  // stored, reset zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gain_offset_chan_14_reg <= cgo_pkg::CGO_REG_RESET;
    end else if (wr_prim14) begin
      gain_offset_chan_14_reg <= bus_req.wdata;
    end
  end

  // Channel 14 mirror
  // stored, reset zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      offset_mirror_chan_14_reg <= cgo_pkg::CGO_REG_RESET;
    end else if (wr_mir14) begin
      offset_mirror_chan_14_reg <= bus_req.wdata;
    end
  end

  // Channel 15 primary
  // stored, reset zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gain_offset_chan_15_reg <= cgo_pkg::CGO_REG_RESET;
    end else if (wr_prim15) begin
      gain_offset_chan_15_reg <= bus_req.wdata;
    end
  end

  // Channel 15 mirror
  // stored, reset zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      offset_mirror_chan_15_reg <= cgo_pkg::CGO_REG_RESET;
    end else if (wr_mir15) begin
      offset_mirror_chan_15_reg <= bus_req.wdata;
    end
  end

  // Global enables; both off after reset so corrections start inert
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= cgo_pkg::CGO_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= bus_req.wdata[cgo_pkg::CGO_CTRL_W-1:0];
    end
  end

  // Nonzero data in a reserved position is legal to store but flagged
  // reserved write watch
  assign rsvd_hit =
    (wr_prim14 && |(bus_req.wdata & cgo_pkg::CGO_PRIM_RSVD_MASK)) ||
    (wr_prim15 && |(bus_req.wdata & cgo_pkg::CGO_PRIM_RSVD_MASK)) ||
    (wr_mir14 && |(bus_req.wdata & cgo_pkg::CGO_MIR_RSVD_MASK)) ||
    (wr_mir15 && |(bus_req.wdata & cgo_pkg::CGO_MIR_RSVD_MASK));
  assign rsvd_clr = wr_stat && bus_req.wdata[cgo_pkg::CGO_STAT_RSVD_BIT];

  // Sticky flag, write one clears; a new hit wins over the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsvd_write_reg <= 1'b0;
    end else if (rsvd_hit) begin
      rsvd_write_reg <= 1'b1;
    end else if (rsvd_clr) begin
      rsvd_write_reg <= 1'b0;
    end
  end

  // Pair comparison, registered so the output is a clean flop
  // mirror pair checked
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      offset_mismatch <= '0;
    end else begin
      offset_mismatch[0] <= offset_value_chan_14 != mirror_value_chan_14;
      offset_mismatch[1] <= offset_value_chan_15 != mirror_value_chan_15;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = cgo_pkg::CGO_REG_RESET;
    case (bus_req.addr)
      cgo_pkg::CGO_ADDR_PRIM14: rd_mux = gain_offset_chan_14_reg;
      cgo_pkg::CGO_ADDR_MIR14: rd_mux = offset_mirror_chan_14_reg;
      cgo_pkg::CGO_ADDR_PRIM15: rd_mux = gain_offset_chan_15_reg;
      cgo_pkg::CGO_ADDR_MIR15: rd_mux = offset_mirror_chan_15_reg;
      cgo_pkg::CGO_ADDR_CTRL: begin
        rd_mux[cgo_pkg::CGO_CTRL_W-1:0] = ctrl_reg;
      end
      cgo_pkg::CGO_ADDR_STAT: begin
        rd_mux[cgo_pkg::CGO_STAT_MIS14_BIT] = offset_mismatch[0];
        rd_mux[cgo_pkg::CGO_STAT_MIS15_BIT] = offset_mismatch[1];
        rd_mux[cgo_pkg::CGO_STAT_RSVD_BIT] = rsvd_write_reg;
      end
      default: rd_mux = cgo_pkg::CGO_REG_RESET;
    endcase
  end

  // Read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= cgo_pkg::CGO_REG_RESET;
    end else if (bus_req.rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= cgo_pkg::CGO_REG_RESET;
    end
  end

  // Correction datapaths; offset comes from the primary register only
  cgo_chan_corr u_chan_14 (
    .clk(clk),
    .sys_rst(sys_rst),
    .samp_in(samp_in_14),
    .gain_code(gain_code_chan_14),
    .offset_value(offset_value_chan_14),
    .gain_en(global_gain_enable),
    .offset_en(global_offset_enable),
    .samp_out(samp_out_14)
  );

  cgo_chan_corr u_chan_15 (
    .clk(clk),
    .sys_rst(sys_rst),
    .samp_in(samp_in_15),
    .gain_code(gain_code_chan_15),
    .offset_value(offset_value_chan_15),
    .gain_en(global_gain_enable),
    .offset_en(global_offset_enable),
    .samp_out(samp_out_15)
  );

  // Offset widened to output width, used only by the checks below
  assign off14_ext = {{4{offset_value_chan_14[9]}}, offset_value_chan_14};

  a_reset_clears_all: assert property (@(posedge clk)
    sys_rst |=> (gain_offset_chan_14_reg == 16'h0000) &&
      (offset_mirror_chan_14_reg == 16'h0000) &&
      (gain_offset_chan_15_reg == 16'h0000) &&
      (offset_mirror_chan_15_reg == 16'h0000) && (ctrl_reg == 2'h0))
    else $error("registers not zero after reset");

  a_write_read_back: assert property (@(posedge clk) disable iff (sys_rst)
    wr_mir15 ##1 (bus_req.rd && bus_req.addr == cgo_pkg::CGO_ADDR_MIR15)
      |=> rdata == $past(bus_req.wdata, 2))
    else $error("mirror 15 readback differs from write");

  a_reserved_bits_kept: assert property (@(posedge clk) disable iff (sys_rst)
    wr_prim14 |=> gain_offset_chan_14_reg[10] == $past(bus_req.wdata[10]))
    else $error("reserved bit of primary 14 not stored");

  a_unmapped_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
    bus_req.rd && (bus_req.addr < cgo_pkg::CGO_ADDR_PRIM14) |=> rdata == 16'h0000)
    else $error("unmapped read returned data");

  a_gain_off_bypass: assert property (@(posedge clk) disable iff (sys_rst)
    samp_in_15.valid && !global_gain_enable && !global_offset_enable
      |=> samp_out_15.valid && (samp_out_15.data == $past(samp_in_15.data)))
    else $error("channel 15 changed with corrections off");

  a_gain_two_db: assert property (@(posedge clk) disable iff (sys_rst)
    samp_in_14.valid && global_gain_enable && !global_offset_enable &&
      (gain_code_chan_14 == 5'h0a) && (samp_in_14.data == 14'h0400)
      |=> samp_out_14.data == 14'h0509)
    else $error("2 dB gain on 1024 did not give 1289");

  a_offset_added: assert property (@(posedge clk) disable iff (sys_rst)
    samp_in_14.valid && !global_gain_enable && global_offset_enable &&
      (samp_in_14.data[13] == samp_in_14.data[12])
      |=> samp_out_14.data == $past(samp_in_14.data) + $past(off14_ext))
    else $error("channel 14 offset not added as signed value");

  a_mismatch_follows: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 offset_mismatch[1] == $past(offset_value_chan_15 != mirror_value_chan_15))
    else $error("channel 15 mismatch flag wrong");

  // sticky flag held; software may clear it in the very next cycle
  a_rsvd_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    rsvd_write_reg && !rsvd_clr |=> rsvd_write_reg)
    else $error("reserved write flag did not stick");

  a_rsvd_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    rsvd_hit |=> rsvd_write_reg)
    else $error("reserved write did not set flag");

  a_rsvd_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
    rsvd_clr && !rsvd_hit |=> !rsvd_write_reg)
    else $error("reserved write flag not cleared");

  a_rdata_idle_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !bus_req.rd |=> rdata == 16'h0000)
    else $error("read data present without a read");

  a_write_lands_15: assert property (@(posedge clk) disable iff (sys_rst)
    wr_prim15 |=> gain_offset_chan_15_reg == $past(bus_req.wdata))
    else $error("primary 15 write not stored");

  a_mirror_lands_14: assert property (@(posedge clk) disable iff (sys_rst)
    wr_mir14 |=> offset_mirror_chan_14_reg == $past(bus_req.wdata))
    else $error("mirror 14 write not stored");

  a_ctrl_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
    wr_ctrl |=> ctrl_reg == $past(bus_req.wdata[cgo_pkg::CGO_CTRL_W-1:0]))
    else $error("control write not stored");

  a_mismatch_follows_14: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 offset_mismatch[0] == $past(offset_value_chan_14 != mirror_value_chan_14))
    else $error("channel 14 mismatch flag wrong");

  a_offset_off_14: assert property (@(posedge clk) disable iff (sys_rst)
    samp_in_14.valid && !global_gain_enable && !global_offset_enable
      |=> samp_out_14.data == $past(samp_in_14.data))
    else $error("channel 14 changed with corrections off");

  a_gain_code_zero: assert property (@(posedge clk) disable iff (sys_rst)
    samp_in_14.valid && global_gain_enable && !global_offset_enable && (gain_code_chan_14 == 5'h00)
      |=> samp_out_14.data == $past(samp_in_14.data))
    else $error("gain code zero changed channel 14");

  // top code floors toward minus infinity on a negative sample
  a_gain_top_floor: assert property (@(posedge clk) disable iff (sys_rst)
    samp_in_15.valid && global_gain_enable && !global_offset_enable &&
      (gain_code_chan_15 == 5'h1f) && (samp_in_15.data == 14'h3c00)
      |=> samp_out_15.data == 14'h37d5)
    else $error("6.2 dB gain on -1024 did not give -2091");

endmodule : cgo_bank

// [src/cgo_chan_corr.sv]
// Purpose: One channel of gain and offset correction
// Assumes: Signed 14-bit samples on the register clock
// Notes: One cycle latency, output saturates to 14 bits
`timescale 1ns/1ps
module cgo_chan_corr (
  input wire logic clk,
  input wire logic sys_rst,
  input wire cgo_pkg::cgo_sample_t samp_in,
  input wire logic [4:0] gain_code,
  input wire logic [9:0] offset_value,
  input wire logic gain_en,
  input wire logic offset_en,
  output cgo_pkg::cgo_sample_t samp_out
);

  logic [16:0] factor;
  logic signed [31:0] product;
  logic signed [17:0] scaled;
  logic signed [18:0] off_ext;
  logic signed [18:0] summed;
  logic [13:0] sat;

  // Scale, add offset, then clamp so a large gain never wraps
  always_comb begin
    factor = gain_en ? cgo_pkg::CGO_GAIN_LUT[gain_code] : cgo_pkg::CGO_UNITY;
    product = $signed(samp_in.data) * $signed({1'b0, factor});
    scaled = 18'(product >>> cgo_pkg::CGO_Q_SHIFT);
    off_ext = offset_en ? {{9{offset_value[9]}}, offset_value} : '0;
    summed = {scaled[17], scaled} + off_ext;
    if (summed > cgo_pkg::CGO_SAT_MAX) begin
      sat = cgo_pkg::CGO_OUT_MAX;
    end else if (summed < cgo_pkg::CGO_SAT_MIN) begin
      sat = cgo_pkg::CGO_OUT_MIN;
    end else begin
      sat = summed[13:0];
    end
  end

  // Data holds between samples so downstream sees a stable word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      samp_out <= '0;
    end else begin
      samp_out.valid <= samp_in.valid;
      if (samp_in.valid) begin
        samp_out.data <= sat;
      end
    end
  end

endmodule : cgo_chan_corr

// [src/cgo_pkg.sv]
// Purpose: Shared constants and types for the channel gain/offset bank
// Assumes: 16-bit registers, 8-bit register address, 14-bit samples
// Notes: Gain table is Q14, entry N holds 10^(N*0.2/20)
// Operation
// - Gain field bits 15:11 sets channel gain to N times 0.2 dB
// - Gain code acts only while the global gain enable is 1
// - Offset acts only while the global offset enable is 1
// - Offset bits 9:0 are signed, one LSB of the 14-bit output
// - All channel register fields and reserved bits are read/write and reset to zero; control keeps bits 1:0, status bit 2 is write-one-clear
package cgo_pkg;

  localparam int CGO_ADDR_W = 8;
  localparam int CGO_DATA_W = 16;
  localparam int CGO_OUT_W = 14;

  // Register addresses
  localparam logic [7:0] CGO_ADDR_PRIM14 = 8'h33;
  localparam logic [7:0] CGO_ADDR_MIR14 = 8'h34;
  localparam logic [7:0] CGO_ADDR_PRIM15 = 8'h35;
  localparam logic [7:0] CGO_ADDR_MIR15 = 8'h36;
  localparam logic [7:0] CGO_ADDR_CTRL = 8'h3e;
  localparam logic [7:0] CGO_ADDR_STAT = 8'h3f;

  // Field layout
  localparam int CGO_GAIN_MSB = 15;
  localparam int CGO_GAIN_LSB = 11;
  localparam int CGO_OFF_MSB = 9;
  localparam int CGO_OFF_LSB = 0;
  localparam logic [15:0] CGO_PRIM_RSVD_MASK = 16'h0400;
  localparam logic [15:0] CGO_MIR_RSVD_MASK = 16'hfc00;
  localparam logic [15:0] CGO_REG_RESET = 16'h0000;

  // Control and status bits
  localparam int CGO_CTRL_W = 2;
  localparam int CGO_CTRL_GAIN_BIT = 0;
  localparam int CGO_CTRL_OFF_BIT = 1;
  localparam logic [1:0] CGO_CTRL_RESET = 2'h0;
  localparam int CGO_STAT_MIS14_BIT = 0;
  localparam int CGO_STAT_MIS15_BIT = 1;
  localparam int CGO_STAT_RSVD_BIT = 2;

  // Datapath scaling
  localparam int CGO_Q_SHIFT = 14;
  localparam logic [16:0] CGO_UNITY = 17'h04000;
  localparam logic signed [18:0] CGO_SAT_MAX = 19'sh01fff;
  localparam logic signed [18:0] CGO_SAT_MIN = 19'sh7e000;
  localparam logic [13:0] CGO_OUT_MAX = 14'h1fff;
  localparam logic [13:0] CGO_OUT_MIN = 14'h2000;

  // Linear factor per gain code, 0 dB to 6.2 dB in 0.2 dB steps
  localparam logic [16:0] CGO_GAIN_LUT [32] = '{
    17'h04000, 17'h0417e, 17'h04304, 17'h04494,
    17'h0462d, 17'h047cf, 17'h0497b, 17'h04b32,
    17'h04cf2, 17'h04ebd, 17'h05092, 17'h05273,
    17'h0545e, 17'h05655, 17'h05858, 17'h05a67,
    17'h05c82, 17'h05eaa, 17'h060de, 17'h06320,
    17'h0656f, 17'h067cc, 17'h06a37, 17'h06cb0,
    17'h06f38, 17'h071cf, 17'h07476, 17'h0772c,
    17'h079f3, 17'h07cca, 17'h07fb2, 17'h082ac
  };

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cgo_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [13:0] data;
  } cgo_sample_t;

endpackage : cgo_pkg

// [tb/testbench.sv]
// Purpose: Self-checking bench for the channel 14/15 gain and offset bank
// Assumes: Fixed read and sample latencies of one cycle, synchronous reset
// Notes: Expected gains are computed here in floating point, not from the design table
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic sys_rst;
  cgo_pkg::cgo_bus_req_t bus_req;
  logic [15:0] rdata;
  cgo_pkg::cgo_sample_t samp_in_14;
  cgo_pkg::cgo_sample_t samp_in_15;
  cgo_pkg::cgo_sample_t samp_out_14;
  cgo_pkg::cgo_sample_t samp_out_15;
  logic [1:0] offset_mismatch;
  int mismatches;
  int tests_run;
  logic [15:0] prim_s [2];
  logic [1:0] ctrl_s;

  cgo_bank cgo_bank_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus_req(bus_req),
    .rdata(rdata),
    .samp_in_14(samp_in_14),
    .samp_in_15(samp_in_15),
    .samp_out_14(samp_out_14),
    .samp_out_15(samp_out_15),
    .offset_mismatch(offset_mismatch)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // One-cycle write; a gap cycle follows since the next task waits for an edge
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 16'h0000};
  endtask : reg_wr

  // Read strobe, then data checked in the single cycle where it stands
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 16'h0000};
    #1;
    check("rdata", rdata, exp);
  endtask : reg_rd

  // Reference correction: gain as 10^(N/100) in Q14, floor, offset, saturation
  function automatic logic [13:0] ref_out(input logic [13:0] x, input logic [15:0] prim, input logic [1:0] ctrl);
    int f;
    int v;
    f = 16384;
    if (ctrl[0]) f = $rtoi(16384.0 * (10.0 ** (prim[15:11] / 100.0)) + 0.5);
    v = (int'($signed(x)) * f) >>> 14;
    if (ctrl[1]) v = v + int'($signed(prim[9:0]));
    if (v > 8191) v = 8191;
    if (v < -8192) v = -8192;
    return v[13:0];
  endfunction : ref_out

  // Configure both channels with matching mirrors, shadowed for expectations
  task automatic cfg(input logic [1:0] ctrl, input logic [15:0] p14, input logic [15:0] p15);
    reg_wr(cgo_pkg::CGO_ADDR_PRIM14, p14);
    reg_wr(cgo_pkg::CGO_ADDR_MIR14, {6'h00, p14[9:0]});
    reg_wr(cgo_pkg::CGO_ADDR_PRIM15, p15);
    reg_wr(cgo_pkg::CGO_ADDR_MIR15, {6'h00, p15[9:0]});
    reg_wr(cgo_pkg::CGO_ADDR_CTRL, {14'h0000, ctrl});
    prim_s[0] = p14;
    prim_s[1] = p15;
    ctrl_s = ctrl;
  endtask : cfg

  // One sample per channel, result checked the cycle after it is taken
  task automatic samp(input logic [13:0] x14, input logic [13:0] x15);
    @(posedge clk);
    samp_in_14 <= '{valid: 1'b1, data: x14};
    samp_in_15 <= '{valid: 1'b1, data: x15};
    @(posedge clk);
    samp_in_14 <= '{valid: 1'b0, data: 14'h0000};
    samp_in_15 <= '{valid: 1'b0, data: 14'h0000};
    #1;
    check("valid14", {15'h0000, samp_out_14.valid}, 16'h0001);
    check("valid15", {15'h0000, samp_out_15.valid}, 16'h0001);
    check("out14", {2'h0, samp_out_14.data}, {2'h0, ref_out(x14, prim_s[0], ctrl_s)});
    check("out15", {2'h0, samp_out_15.data}, {2'h0, ref_out(x15, prim_s[1], ctrl_s)});
    // Valid stands one cycle only
    @(posedge clk);
    #1;
    check("valid off", {14'h0000, samp_out_14.valid, samp_out_15.valid}, 16'h0000);
  endtask : samp

  // Reset values of all four bank registers
  task automatic scen_reset_values();
    for (int a = 8'h33; a <= 8'h36; a++) begin
      reg_rd(a[7:0], cgo_pkg::CGO_REG_RESET);
    end
  endtask : scen_reset_values

  // Write then read back to back, reserved bits included; rdata falls back to zero
  task automatic scen_read_write();
    logic [15:0] pat [2];
    pat[0] = 16'hffff;
    pat[1] = 16'ha5a5;
    for (int a = 8'h33; a <= 8'h36; a++) begin
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a[7:0], wdata: pat[p]};
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a[7:0], wdata: 16'h0000};
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 16'h0000};
        #1;
        check("readback", rdata, pat[p]);
        @(posedge clk);
        #1;
        check("rdata idle", rdata, 16'h0000);
      end
    end
    // Unmapped reads on both sides of the bank
    reg_rd(8'h32, 16'h0000);
    reg_rd(8'h40, 16'h0000);
  endtask : scen_read_write

  // Gain codes at both ends and mid-range, offset held off
  task automatic scen_gain();
    logic [4:0] codes [3];
    codes[0] = 5'h00;
    codes[1] = 5'h0a;
    codes[2] = 5'h1f;
    for (int i = 0; i < 3; i++) begin
      cfg(2'h1, {codes[i], 1'b0, 10'h07f}, {codes[2 - i], 1'b0, 10'h3f0});
      samp(14'h0400, 14'h3c00);
      // Known point: code 10 on 1024 gives 1289, taken from the output itself
      if (i == 1) begin
        check("gain point", {2'h0, samp_out_14.data}, 16'h0509);
      end
    end
    cfg(2'h0, 16'hf9ff, 16'hf800);
    samp(14'h03e8, 14'h1234);
  endtask : scen_gain

  // Signed offsets with gain off, then both on with saturation
  task automatic scen_offset();
    cfg(2'h2, 16'hfbfb, 16'h0200);
    samp(14'h0064, 14'h0000);
    cfg(2'h2, 16'h01ff, 16'h0200);
    samp(14'h1f00, 14'h2010);
    cfg(2'h3, 16'hf9ff, 16'h7a00);
    samp(14'h1800, 14'h2100);
  endtask : scen_offset

  // Channel 15 primary and mirror offsets disagree, then agree again while channel 14 is made to disagree
  task automatic scen_mismatch();
    cfg(2'h0, 16'h0011, 16'h0022);
    reg_wr(cgo_pkg::CGO_ADDR_MIR15, 16'h0023);
    repeat (2) @(posedge clk);
    #1;
    check("mismatch flags", {14'h0000, offset_mismatch}, 16'h0002);
    reg_rd(cgo_pkg::CGO_ADDR_STAT, 16'h0002);
    reg_wr(cgo_pkg::CGO_ADDR_MIR14, 16'h0012);
    reg_wr(cgo_pkg::CGO_ADDR_MIR15, 16'h0022);
    repeat (2) @(posedge clk);
    #1;
    check("mismatch flags", {14'h0000, offset_mismatch}, 16'h0001);
  endtask : scen_mismatch

  // Control and status readback with back-to-back reads, then status clear
  task automatic scen_status();
    reg_wr(cgo_pkg::CGO_ADDR_CTRL, 16'hffff);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: cgo_pkg::CGO_ADDR_CTRL, wdata: 16'h0000};
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: cgo_pkg::CGO_ADDR_STAT, wdata: 16'h0000};
    #1;
    check("ctrl", rdata, 16'h0003);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 16'h0000};
    #1;
    check("status", rdata, 16'h0004);
    reg_wr(cgo_pkg::CGO_ADDR_STAT, 16'h0004);
    reg_rd(cgo_pkg::CGO_ADDR_STAT, 16'h0000);
    reg_wr(cgo_pkg::CGO_ADDR_CTRL, 16'h0000);
  endtask : scen_status

  // Reset in mid-run clears registers and outputs; first read waits one cycle
  task automatic scen_reset_mid();
    reg_wr(cgo_pkg::CGO_ADDR_CTRL, 16'h0003);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check("mismatch rst", {14'h0000, offset_mismatch}, 16'h0000);
    check("out14 rst", {1'b0, samp_out_14}, 16'h0000);
    check("out15 rst", {1'b0, samp_out_15}, 16'h0000);
    reg_rd(cgo_pkg::CGO_ADDR_CTRL, 16'h0000);
    scen_reset_values();
  endtask : scen_reset_mid

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  // Main sequence
  initial begin
    mismatches = 0;
    tests_run = 0;
    ctrl_s = 2'h0;
    sys_rst = 1'b1;
    bus_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 16'h0000};
    samp_in_14 = '{valid: 1'b0, data: 14'h0000};
    samp_in_15 = '{valid: 1'b0, data: 14'h0000};
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    scen_reset_values();
    scen_read_write();
    scen_status();
    scen_gain();
    scen_offset();
    scen_mismatch();
    scen_reset_mid();
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule : testbench
